// ==== hdl/ast_pkg.sv ====
// Shared constants and carrier types for the async serial transceiver
package ast_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned BAUD_DIV_W    = 16;
	localparam logic [4:0]  RT_START_S1   = 5'h03;
	localparam logic [4:0]  RT_START_S2   = 5'h05;
	localparam logic [4:0]  RT_START_S3   = 5'h07;
	localparam logic [4:0]  RT_MAJ_FIRST  = 5'h08;
	localparam logic [4:0]  RT_MAJ_LAST   = 5'h0a;
	localparam logic [4:0]  RT_BIT_END    = 5'h10;
	localparam logic [3:0]  TX_RT_LAST    = 4'hf;

	// ------------------------------------------------------------
	// Character framing
	// ------------------------------------------------------------
	localparam logic [3:0]  DATA_LAST_8   = 4'h7;
	localparam logic [3:0]  DATA_LAST_9   = 4'h8;
	localparam logic [3:0]  FRAME_BITS_8  = 4'ha;
	localparam logic [3:0]  FRAME_BITS_9  = 4'hb;
	localparam logic [2:0]  SEARCH_ONES   = 3'h7;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic module_en;
		logic tx_en;
		logic rx_en;
		logic char9;
		logic long_break;
		logic send_break;
		logic tx_invert;
		logic tx_empty_irq_en;
		logic rx_full_irq_en;
	} ast_ctrl_t;

	typedef struct packed {
		logic tx_empty;
		logic rx_full;
		logic overrun;
		logic noise;
		logic framing;
		logic parity;
		logic brk;
		logic rx_busy;
	} ast_stat_t;

	localparam ast_stat_t STAT_RESET = '{tx_empty: 1'b1, default: 1'b0};

endpackage : ast_pkg

// ==== hdl/ast_baud_gen.sv ====
// Oversample tick generator shared by transmitter and receiver
`timescale 1ns/1ps
`default_nettype none
module ast_baud_gen
	import ast_pkg::*;
(
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_b,
	input  wire logic                  i_run,
	input  wire logic [BAUD_DIV_W-1:0] i_div,
	output logic                       o_tick
);
	logic [BAUD_DIV_W-1:0] cnt_q;

	// One tick every i_div+1 clocks, sixteen ticks per bit
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			cnt_q  <= '0;
			o_tick <= 1'b0;
		end
		else if (!i_run)
		begin
			cnt_q  <= '0;
			o_tick <= 1'b0;
		end
		else if (cnt_q >= i_div)
		begin
			cnt_q  <= '0;
			o_tick <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_q + 1'b1;
			o_tick <= 1'b0;
		end
	end
endmodule : ast_baud_gen
`default_nettype wire

// ==== hdl/ast_serial_unit.sv ====
// Async serial transceiver: transmitter, receiver, flags
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module ast_serial_unit
	import ast_pkg::*;
(
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_b,
	input  wire ast_ctrl_t             i_ctrl,
	input  wire logic [BAUD_DIV_W-1:0] i_baud_div,
	input  wire logic                  i_status_rd,
	input  wire logic                  i_data_wr,
	input  wire logic [7:0]            i_tx_data,
	input  wire logic                  i_tx_ninth_bit,
	input  wire logic                  i_data_rd,
	input  wire logic                  i_break_clr,
	input  wire logic                  i_rx_line,
	output logic                       o_tx_line,
	output logic                       o_tx_pin_owned,
	output logic                       o_rx_pin_owned,
	output logic [7:0]                 o_rx_data,
	output logic                       o_rx_ninth_bit,
	output ast_stat_t                  o_status,
	output logic                       o_tx_irq,
	output logic                       o_rx_irq
);
	typedef enum logic [3:0] {
		TX_IDLE  = 4'b0001,
		TX_FRAME = 4'b0010,
		TX_BREAK = 4'b0100,
		TX_MARK  = 4'b1000
	} ast_tx_state_t;

	typedef enum logic [4:0] {
		RX_SEARCH = 5'b00001,
		RX_START  = 5'b00010,
		RX_DATA   = 5'b00100,
		RX_STOP   = 5'b01000,
		RX_EXTRA  = 5'b10000
	} ast_rx_state_t;

	function automatic logic maj3(input logic [2:0] s);
		maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction : maj3

	logic tick;
	logic en_tx;
	logic en_rx;

	assign en_tx = i_ctrl.module_en & i_ctrl.tx_en;
	assign en_rx = i_ctrl.module_en & i_ctrl.rx_en;

	ast_baud_gen u_baud (
		.i_clk   (i_clk),
		.i_rst_b (i_rst_b),
		.i_run   (i_ctrl.module_en),
		.i_div   (i_baud_div),
		.o_tick  (tick)
	);

	// ------------------------------------------------------------
	// Transmitter
	// ------------------------------------------------------------
	ast_tx_state_t tx_st_q;
	logic [10:0]   tx_sh_q;
	logic [3:0]    tx_bits_q;
	logic [3:0]    tx_rt_q;
	logic [7:0]    tx_buf_q;
	logic          tx_buf_ninth_q;
	logic          tx_en_q;
	logic          idle_pend_q;
	logic          status_seen_q;
	logic          tx_load;
	logic          tx_pick;
	logic          bit_end;
	logic          frame_end;
	logic [3:0]    frame_len;
	logic          tx_level;

	assign frame_len = i_ctrl.char9 ? FRAME_BITS_9 : FRAME_BITS_8;
	assign bit_end   = tick && (tx_rt_q == TX_RT_LAST);
	assign frame_end = bit_end && (tx_bits_q == 4'h1);
	// Frames leave idle only on a tick, so the first bit is a full 16 ticks too
	assign tx_pick   = (tx_st_q == TX_IDLE && tick) || frame_end;
	assign tx_load   = en_tx && !o_status.tx_empty && !i_ctrl.send_break && !idle_pend_q;

	// Write buffer; ninth bit latched with the byte
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			tx_buf_q       <= 8'h00;
			tx_buf_ninth_q <= 1'b0;
		end
		else if (i_data_wr)
		begin
			tx_buf_q       <= i_tx_data;
			tx_buf_ninth_q <= i_tx_ninth_bit;
		end
	end

	// Off-then-on during a frame queues an idle character
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			tx_en_q     <= 1'b0;
			idle_pend_q <= 1'b0;
		end
		else
		begin
			tx_en_q <= en_tx;
			if (!i_ctrl.module_en)
				idle_pend_q <= 1'b0;
			else if (en_tx && !tx_en_q)
				idle_pend_q <= 1'b1;
			else if (tx_pick && idle_pend_q && en_tx && !i_ctrl.send_break)
				idle_pend_q <= 1'b0;
		end
	end

	// Frame sequencer
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			tx_st_q   <= TX_IDLE;
			tx_sh_q   <= '1;
			tx_bits_q <= 4'h0;
			tx_rt_q   <= 4'h0;
		end
		else if (!i_ctrl.module_en)
		begin
			tx_st_q   <= TX_IDLE;
			tx_sh_q   <= '1;
			tx_bits_q <= 4'h0;
			tx_rt_q   <= 4'h0;
		end
		else if (tx_pick)
		begin
			tx_rt_q <= 4'h0;
			if (tx_st_q == TX_BREAK && !i_ctrl.send_break)
			begin
				tx_st_q   <= TX_MARK;
				tx_sh_q   <= '1;
				tx_bits_q <= 4'h1;
			end
			else if (en_tx && i_ctrl.send_break)
			begin
				tx_st_q   <= TX_BREAK;
				tx_sh_q   <= '0;
				tx_bits_q <= frame_len + {3'h0, i_ctrl.long_break};
			end
			else if (en_tx && idle_pend_q)
			begin
				tx_st_q   <= TX_FRAME;
				tx_sh_q   <= '1;
				tx_bits_q <= frame_len;
			end
			else if (tx_load)
			begin
				tx_st_q   <= TX_FRAME;
				tx_sh_q   <= i_ctrl.char9 ? {1'b1, tx_buf_ninth_q, tx_buf_q, 1'b0} : {2'b11, tx_buf_q, 1'b0};
				tx_bits_q <= frame_len;
			end
			else
			begin
				tx_st_q   <= TX_IDLE;
				tx_sh_q   <= '1;
				tx_bits_q <= 4'h0;
			end
		end
		else if (tick)
		begin
			tx_rt_q <= tx_rt_q + 1'b1;
			if (bit_end)
			begin
				tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
				tx_bits_q <= tx_bits_q - 1'b1;
			end
		end
	end

	// Break level kept apart from the shifter, which a 12-bit break outruns
	assign tx_level = (tx_st_q == TX_IDLE) ? 1'b1 : (tx_st_q == TX_BREAK) ? 1'b0 : tx_sh_q[0];

	// Pin drive; released when the module is off
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_tx_line      <= 1'b1;
			o_tx_pin_owned <= 1'b0;
			o_rx_pin_owned <= 1'b0;
		end
		else
		begin
			o_tx_line      <= tx_level ^ i_ctrl.tx_invert;
			o_tx_pin_owned <= en_tx;
			o_rx_pin_owned <= en_rx;
		end
	end

	// ------------------------------------------------------------
	// Receiver
	// ------------------------------------------------------------
	ast_rx_state_t rx_st_q;
	logic [4:0]    rt_q;
	logic [4:0]    rt_n;
	logic [2:0]    hist_q;
	logic [1:0]    vfy_q;
	logic [2:0]    maj_q;
	logic [2:0]    maj_n;
	logic [3:0]    bitn_q;
	logic [8:0]    rx_sh_q;
	logic          prev_one_q;
	logic [4:0]    edge_rt_q;
	logic          edge_seen_q;
	logic          last_smp_q;
	logic          noise_acc_q;
	logic          zeros_q;
	logic          bit_val;
	logic          bit_noisy;
	logic          rx_done;
	logic          rx_break;
	logic          rx_frame_err;
	logic [3:0]    data_last;

	assign rt_n      = rt_q + 1'b1;
	assign maj_n     = {maj_q[1:0], i_rx_line};
	assign bit_val   = maj3(maj_q);
	assign bit_noisy = (maj_q != 3'h0) && (maj_q != 3'h7);
	assign data_last = i_ctrl.char9 ? DATA_LAST_9 : DATA_LAST_8;

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			rx_st_q      <= RX_SEARCH;
			rt_q         <= 5'h00;
			hist_q       <= 3'h0;
			vfy_q        <= 2'h0;
			maj_q        <= 3'h0;
			bitn_q       <= 4'h0;
			rx_sh_q      <= 9'h000;
			prev_one_q   <= 1'b0;
			edge_rt_q    <= 5'h00;
			edge_seen_q  <= 1'b0;
			last_smp_q   <= 1'b1;
			noise_acc_q  <= 1'b0;
			zeros_q      <= 1'b0;
			rx_done      <= 1'b0;
			rx_break     <= 1'b0;
			rx_frame_err <= 1'b0;
		end
		else
		begin
			rx_done <= 1'b0;
			if (!en_rx)
			begin
				rx_st_q <= RX_SEARCH;
				hist_q  <= 3'h0;
			end
			else if (tick)
			begin
				last_smp_q <= i_rx_line;
				if (rx_st_q == RX_SEARCH)
				begin
					hist_q <= {hist_q[1:0], i_rx_line};
					if (hist_q == SEARCH_ONES && !i_rx_line)
					begin
						rx_st_q     <= RX_START;
						rt_q        <= 5'h01;
						noise_acc_q <= 1'b0;
						zeros_q     <= 1'b1;
						prev_one_q  <= 1'b0;
					end
				end
				else
				begin
					rt_q <= rt_n;
					if (rt_n >= RT_MAJ_FIRST && rt_n <= RT_MAJ_LAST)
						maj_q <= maj_n;
					// Falls at or after the majority window are noise, not bit edges
					if (prev_one_q && !edge_seen_q && last_smp_q && !i_rx_line && rt_n < RT_MAJ_FIRST)
					begin
						edge_seen_q <= 1'b1;
						edge_rt_q   <= rt_n;
					end
					if (rx_st_q == RX_START)
					begin
						if (rt_n == RT_START_S1 || rt_n == RT_START_S2)
							vfy_q <= {vfy_q[0], i_rx_line};
						if (rt_n == RT_START_S3)
						begin
							// Two or more ones among ticks 3, 5, 7 fail verification
							if ({1'b0, vfy_q[1]} + {1'b0, vfy_q[0]} + {1'b0, i_rx_line} >= 2'h2)
							begin
								rx_st_q <= RX_SEARCH;
								hist_q  <= 3'h0;
								rt_q    <= 5'h00;
							end
							else if (vfy_q != 2'h0 || i_rx_line)
								noise_acc_q <= 1'b1;
						end
					end
					if (rt_n == RT_BIT_END)
					begin
						edge_seen_q <= 1'b0;
						rt_q        <= 5'h00;
						// Realign to a 1-to-0 edge seen inside this bit
						if (rx_st_q != RX_START && prev_one_q && !bit_val && edge_seen_q)
							// Wraps below zero, so a late edge delays the next bit
							rt_q <= 5'h01 - edge_rt_q;
						case (rx_st_q)
							RX_START:
							begin
								if (maj_q != 3'h0)
									noise_acc_q <= 1'b1;
								rx_st_q <= RX_DATA;
								bitn_q  <= 4'h0;
							end
							RX_DATA:
							begin
								if (bit_noisy)
									noise_acc_q <= 1'b1;
								rx_sh_q[bitn_q] <= bit_val;
								prev_one_q      <= bit_val;
								zeros_q         <= zeros_q & !bit_val;
								bitn_q          <= bitn_q + 1'b1;
								if (bitn_q == data_last)
									rx_st_q <= RX_STOP;
							end
							RX_STOP:
							begin
								if (bit_noisy)
									noise_acc_q <= 1'b1;
								rx_frame_err <= !bit_val;
								rx_break     <= 1'b0;
								if (zeros_q && !bit_val && i_ctrl.long_break)
									rx_st_q <= RX_EXTRA;
								else
								begin
									rx_break <= zeros_q && !bit_val;
									rx_done  <= 1'b1;
									rx_st_q  <= RX_SEARCH;
									hist_q   <= 3'h0;
								end
							end
							default:
							begin
								if (bit_noisy)
									noise_acc_q <= 1'b1;
								rx_break <= !bit_val;
								rx_done  <= 1'b1;
								rx_st_q  <= RX_SEARCH;
								hist_q   <= 3'h0;
							end
						endcase
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Receive buffer and status flags
	// ------------------------------------------------------------
	logic rd_armed_q;

	// Status read arms the second step of each two-step clear
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			status_seen_q <= 1'b0;
			rd_armed_q    <= 1'b0;
		end
		else
		begin
			if (i_status_rd)
				status_seen_q <= 1'b1;
			else if (i_data_wr)
				status_seen_q <= 1'b0;
			if (i_status_rd)
				rd_armed_q <= 1'b1;
			else if (i_data_rd)
				rd_armed_q <= 1'b0;
		end
	end

	// Clears first, sets after (tx_empty sets take priority in its if-else), so a same-cycle event wins
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_status       <= STAT_RESET;
			o_rx_data      <= 8'h00;
			o_rx_ninth_bit <= 1'b0;
		end
		else
		begin
			o_status.rx_busy <= en_rx && (rx_st_q != RX_SEARCH);
			o_status.parity  <= 1'b0;
			if (!i_ctrl.module_en)
				o_status.tx_empty <= 1'b1;
			else if (tx_pick && tx_load && (tx_st_q != TX_BREAK))
				o_status.tx_empty <= 1'b1;
			else if (status_seen_q && i_data_wr)
				o_status.tx_empty <= 1'b0;
			if (rd_armed_q && i_data_rd)
			begin
				o_status.rx_full <= 1'b0;
				o_status.overrun <= 1'b0;
				o_status.noise   <= 1'b0;
				o_status.framing <= 1'b0;
			end
			if (i_break_clr)
				o_status.brk <= 1'b0;
			if (rx_done)
			begin
				if (o_status.rx_full && !(rd_armed_q && i_data_rd))
					o_status.overrun <= 1'b1;
				else
				begin
					o_status.rx_full <= 1'b1;
					o_status.framing <= rx_frame_err || rx_break;
					o_status.noise   <= noise_acc_q;
					if (rx_break)
					begin
						o_status.brk   <= 1'b1;
						o_rx_data      <= 8'h00;
						o_rx_ninth_bit <= 1'b0;
					end
					else
					begin
						o_rx_data      <= rx_sh_q[7:0];
						o_rx_ninth_bit <= i_ctrl.char9 ? rx_sh_q[8] : rx_sh_q[7];
					end
				end
			end
		end
	end

	// Interrupt requests follow the flags and their enables
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_tx_irq <= 1'b0;
			o_rx_irq <= 1'b0;
		end
		else
		begin
			o_tx_irq <= en_tx && o_status.tx_empty && i_ctrl.tx_empty_irq_en;
			o_rx_irq <= o_status.rx_full && i_ctrl.rx_full_irq_en;
		end
	end
endmodule : ast_serial_unit
`default_nettype wire

// ==== sim/ast_line_peer.sv ====
// Remote serial peer that drives the receive line
`timescale 1ns/1ps
`default_nettype none
module ast_line_peer #(
	parameter int BIT_CLKS = 32
) (
	input  wire logic i_clk,
	output logic      o_line
);
	// ----
	// Line driver
	// ----
	// Pulled-up line: idle is high
	initial o_line = 1'b1;

	// LSB first, then two idle bits so the start search sees ones again
	task automatic send(input logic [11:0] bits, input int n);
		@(posedge i_clk);
		for (int i = 0; i < n + 2; i++)
		begin
			o_line <= (i < n) ? bits[i] : 1'b1;
			repeat (BIT_CLKS) @(posedge i_clk);
		end
	endtask : send

	// Short low spike, too short to pass as a start bit
	task automatic glitch();
		@(posedge i_clk);
		o_line <= 1'b0;
		repeat (3) @(posedge i_clk);
		o_line <= 1'b1;
		repeat (2 * BIT_CLKS) @(posedge i_clk);
	endtask : glitch

	// Like send, with a one-sample spike at mid-bit of bit k
	task automatic send_spiked(input logic [11:0] bits, input int n, input int k);
		@(posedge i_clk);
		for (int i = 0; i < n + 2; i++)
		begin
			o_line <= (i < n) ? bits[i] : 1'b1;
			if (i == k)
			begin
				repeat (BIT_CLKS / 2) @(posedge i_clk);
				o_line <= ~bits[i];
				repeat (2) @(posedge i_clk);
				o_line <= bits[i];
				repeat (BIT_CLKS / 2 - 2) @(posedge i_clk);
			end
			else
				repeat (BIT_CLKS) @(posedge i_clk);
		end
	endtask : send_spiked
endmodule : ast_line_peer
`default_nettype wire

// ==== sim/ast_serial_unit_chk.sv ====
// Port-level assertions for the async serial transceiver
`timescale 1ns/1ps
`default_nettype none
module ast_serial_unit_chk
	import ast_pkg::*;
(
	input wire logic       i_clk,
	input wire logic       i_rst_b,
	input wire ast_ctrl_t  i_ctrl,
	input wire logic       i_data_rd,
	input wire logic       o_tx_line,
	input wire logic       o_tx_pin_owned,
	input wire logic       o_rx_pin_owned,
	input wire logic [7:0] o_rx_data,
	input wire logic       o_rx_ninth_bit,
	input wire ast_stat_t  o_status,
	input wire logic       o_tx_irq,
	input wire logic       o_rx_irq
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	// ----
	// Assertions
	// ----
	AST_PIN_RELEASE: assert property (!i_ctrl.module_en |=> !o_tx_pin_owned && !o_rx_pin_owned)
		else $error("pins kept after module disable");
	AST_PIN_OWN: assert property (i_ctrl.module_en && i_ctrl.tx_en && i_ctrl.rx_en |=> o_tx_pin_owned && o_rx_pin_owned)
		else $error("pins not taken while enabled");
	AST_TX_IRQ: assert property (o_status.tx_empty && i_ctrl.tx_empty_irq_en && i_ctrl.module_en && i_ctrl.tx_en |=> o_tx_irq)
		else $error("tx irq missing");
	AST_TX_IRQ_OFF: assert property (!i_ctrl.tx_empty_irq_en |=> !o_tx_irq)
		else $error("tx irq while masked");
	AST_RX_IRQ: assert property (o_status.rx_full && i_ctrl.rx_full_irq_en |=> o_rx_irq)
		else $error("rx irq missing");
	AST_RX_IRQ_OFF: assert property (!o_status.rx_full |=> !o_rx_irq)
		else $error("rx irq without full buffer");
	AST_TX_START: assert property ($rose(o_status.tx_empty) && !i_ctrl.send_break |-> ##[0:4] (o_tx_line == i_ctrl.tx_invert))
		else $error("no start bit after buffer transfer");
	AST_RX_HOLD: assert property (o_status.rx_full && !i_data_rd |=> $stable(o_rx_data) && $stable(o_rx_ninth_bit))
		else $error("full buffer overwritten");
	AST_BRK: assert property ($rose(o_status.brk) |-> o_status.framing && o_status.rx_full && o_rx_data == 8'h00 && !o_rx_ninth_bit)
		else $error("break effects incomplete");
	AST_NINTH_COPY: assert property ($changed(o_rx_data) && !i_ctrl.char9 |-> o_rx_ninth_bit == o_rx_data[7])
		else $error("ninth bit not a copy of bit 7");
	AST_BIT_LEN: assert property ($changed(o_tx_line) && $stable(i_ctrl.tx_invert) |=> $stable(o_tx_line) [*8])
		else $error("tx level shorter than a bit");
	// ----
	// Coverage
	// ----
	COV_BRK: cover property ($rose(o_status.brk));
	COV_OVR: cover property ($rose(o_status.overrun));
	COV_FRM: cover property ($rose(o_status.framing) && !o_status.brk);
	COV_NOISE: cover property ($rose(o_status.noise));
endmodule : ast_serial_unit_chk
`default_nettype wire

// ==== sim/ast_serial_unit_bench.sv ====
// Self-checking bench for the async serial transceiver
`timescale 1ns/1ps
`default_nettype none
module ast_serial_unit_bench;
	import ast_pkg::*;
	// Divider 1: tick every 2 clocks, so one bit is 32 clocks
	localparam int BIT_CLKS = 32;
	logic       i_clk, i_rst_b, i_tx_ninth_bit, tx_line, tx_own, rx_own, rx_ninth, tx_irq, rx_irq, rx_line;
	logic [3:0] sw;
	logic [7:0] tx_data, rx_data;
	ast_ctrl_t  ctl;
	ast_stat_t  stat;
	int         n_fail, cmp_count, gap, n;

	ast_serial_unit u_ast_serial_unit (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ctrl(ctl), .i_baud_div(16'h0001),
		.i_status_rd(sw[0]), .i_data_wr(sw[1]), .i_tx_data(tx_data), .i_tx_ninth_bit(i_tx_ninth_bit),
		.i_data_rd(sw[2]), .i_break_clr(sw[3]), .i_rx_line(rx_line), .o_tx_line(tx_line),
		.o_tx_pin_owned(tx_own), .o_rx_pin_owned(rx_own), .o_rx_data(rx_data), .o_rx_ninth_bit(rx_ninth),
		.o_status(stat), .o_tx_irq(tx_irq), .o_rx_irq(rx_irq));
	ast_line_peer #(.BIT_CLKS(BIT_CLKS)) u_ast_line_peer (.i_clk(i_clk), .o_line(rx_line));

	initial
	begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	// ----
	// Tasks
	// ----
	task automatic give_verdict();
		if (n_fail == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	task automatic check(input string what, input logic [15:0] want, input logic [15:0] seen);
		cmp_count++;
		if (seen !== want)
		begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, want, seen);
		end
	endtask : check

	// 0 status read, 1 data write, 2 data read, 3 break clear
	task automatic pulse(input int k);
		@(posedge i_clk);
		sw <= 4'h1 << k;
		@(posedge i_clk);
		sw <= 4'h0;
	endtask : pulse

	task automatic rx_read();
		pulse(0);
		pulse(2);
		@(posedge i_clk);
	endtask : rx_read

	task automatic wait_line(input logic lvl, output int cnt);
		cnt = 0;
		while (tx_line !== lvl)
		begin
			@(posedge i_clk);
			cnt++;
			if (cnt > 4000)
			begin
				check("line wait", lvl, tx_line);
				give_verdict();
			end
		end
	endtask : wait_line

	task automatic line_steady(input string what, input int clks, input logic lvl);
		logic ok;
		ok = 1'b1;
		repeat (clks)
		begin
			@(posedge i_clk);
			ok = ok & (tx_line === lvl);
		end
		check(what, 1'b1, ok);
	endtask : line_steady

	// Sends one character, samples each bit mid-way; tog 1 drops enable, 2 toggles it
	task automatic tx_char(input logic [8:0] d, input int tog, output int gap);
		logic [10:0] want;
		logic [10:0] got;
		int          nb;
		@(posedge i_clk);
		want = ctl.char9 ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
		nb = ctl.char9 ? 11 : 10;
		got = '1;
		tx_data <= d[7:0];
		i_tx_ninth_bit <= d[8];
		pulse(0);
		pulse(1);
		wait_line(ctl.tx_invert, gap);
		repeat (BIT_CLKS / 2) @(posedge i_clk);
		for (int i = 0; i < nb; i++)
		begin
			got[i] = tx_line ^ ctl.tx_invert;
			if (i == 2 && tog > 0)
				ctl.tx_en <= 1'b0;
			if (i == 3 && tog > 1)
				ctl.tx_en <= 1'b1;
			repeat (BIT_CLKS) @(posedge i_clk);
		end
		check("tx frame", want, got);
	endtask : tx_char
	// ----
	// Sequence
	// ----
	initial
	begin
		n_fail = 0;
		cmp_count = 0;
		i_rst_b = 1'b0;
		ctl = '0;
		sw = 4'h0;
		tx_data = 8'h00;
		i_tx_ninth_bit = 1'b0;
		repeat (8) @(posedge i_clk);
		i_rst_b <= 1'b1;
		@(posedge i_clk);
		check("reset line", 1'b1, tx_line);
		check("reset status", STAT_RESET, stat);
		ctl <= '{module_en: 1'b1, tx_en: 1'b1, rx_en: 1'b1, tx_empty_irq_en: 1'b1, rx_full_irq_en: 1'b1, default: 1'b0};
		tx_char(9'h0a5, 0, gap);
		check("preamble", 1'b1, gap > 9 * BIT_CLKS);
		tx_char(9'h05a, 2, gap);
		check("back to back", 1'b1, gap < 2 * BIT_CLKS);
		tx_char(9'h0c3, 1, gap);
		check("queued idle", 1'b1, gap > 9 * BIT_CLKS);
		line_steady("idle after disable", 4 * BIT_CLKS, 1'b1);
		ctl.char9 <= 1'b1;
		ctl.tx_invert <= 1'b1;
		ctl.tx_en <= 1'b1;
		tx_char(9'h1c6, 0, gap);
		check("long preamble", 1'b1, gap > 10 * BIT_CLKS);
		line_steady("inverted idle", BIT_CLKS, 1'b0);
		ctl.char9 <= 1'b0;
		ctl.tx_invert <= 1'b0;
		repeat (BIT_CLKS) @(posedge i_clk);
		ctl.send_break <= 1'b1;
		wait_line(1'b0, gap);
		n = 0;
		while (tx_line === 1'b0 && n < 2000)
		begin
			@(posedge i_clk);
			n++;
			if (n == 400)
				ctl.send_break <= 1'b0;
		end
		check("break length", 20 * BIT_CLKS, n);
		line_steady("break end", BIT_CLKS, 1'b1);
		u_ast_line_peer.send({3'b111, 8'h96, 1'b0}, 10);
		check("rx data", 8'h96, rx_data);
		check("rx ninth copy", 1'b1, rx_ninth);
		check("rx full", 1'b1, stat.rx_full);
		u_ast_line_peer.send({3'b111, 8'h21, 1'b0}, 10);
		check("overrun", 1'b1, stat.overrun);
		check("rx kept", 8'h96, rx_data);
		rx_read();
		check("rx cleared", 2'b00, {stat.rx_full, stat.overrun});
		ctl.char9 <= 1'b1;
		u_ast_line_peer.send({2'b11, 9'h0a5, 1'b0}, 11);
		check("rx 9-bit", 9'h0a5, {rx_ninth, rx_data});
		rx_read();
		ctl.char9 <= 1'b0;
		u_ast_line_peer.send({3'b000, 8'h55, 1'b0}, 10);
		check("framing", 10'h255, {stat.framing, stat.brk, rx_data});
		rx_read();
		check("framing cleared", 1'b0, stat.framing);
		u_ast_line_peer.send(12'h000, 10);
		check("break rx", 11'h700, {stat.brk, stat.framing, stat.rx_full, rx_data});
		pulse(3);
		rx_read();
		ctl.long_break <= 1'b1;
		u_ast_line_peer.send(12'h000, 10);
		check("short zeros", 2'b01, {stat.brk, stat.framing});
		rx_read();
		u_ast_line_peer.send(12'h000, 11);
		check("long break", 1'b1, stat.brk);
		pulse(3);
		rx_read();
		ctl.long_break <= 1'b0;
		u_ast_line_peer.glitch();
		check("glitch ignored", 1'b0, stat.rx_full);
		u_ast_line_peer.send({3'b111, 8'h3a, 1'b0}, 10);
		check("rx after glitch", 8'h3a, rx_data);
		check("rx clean", 1'b0, stat.noise);
		rx_read();
		u_ast_line_peer.send_spiked({3'b111, 8'h3a, 1'b0}, 10, 2);
		check("noisy bit", 9'h13a, {stat.noise, rx_data});
		rx_read();
		ctl.module_en <= 1'b0;
		repeat (3) @(posedge i_clk);
		check("pins released", 2'b00, {tx_own, rx_own});
		give_verdict();
	end
endmodule : ast_serial_unit_bench

bind ast_serial_unit ast_serial_unit_chk u_ast_serial_unit_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
	.i_ctrl(i_ctrl), .i_data_rd(i_data_rd), .o_tx_line(o_tx_line), .o_tx_pin_owned(o_tx_pin_owned),
	.o_rx_pin_owned(o_rx_pin_owned), .o_rx_data(o_rx_data), .o_rx_ninth_bit(o_rx_ninth_bit),
	.o_status(o_status), .o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq));
`default_nettype wire
